// ### src/gate_consts.vh
`ifndef GATE_CONSTS_VH
`define GATE_CONSTS_VH
// Timing at a 10 MHz clock (period 100 ns)
`define CLK_PERIOD_NS 100
`define WARN_TIME_MS 5000
`define FLASH_HALF_MS 1000
`define TICK_MS 1
`define TICK_CYCLES ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define TICK_W 14
`define MS_W 13
// State codes
`define ST_IDLE 3'h0
`define ST_WARN_OPEN 3'h1
`define ST_WARN_CLOSE 3'h2
`define ST_OPENING 3'h3
`define ST_CLOSING 3'h4
`endif

// ### src/gate_motion_controller.v
// What this block does
// - Start ignored while moving the other way
// - Reached limit cuts motors; stop does too except in cord runs
// - Safety bar inhibits closing motor
// - Flash 5 s before and during motion
// - Stop may interrupt motion anytime unless cord-started
// - Enhanced: bar trip reopens gate
// - Multi-gate: pull-cord runs to end unless safety bar trips
// - Multi-gate: local switches also start
// - Remote commands act like local starts
// - Report fully open and fully closed
// - Multi-gate: limit ends, interlock holds
// - Normally-closed safety inputs, open active
`include "gate_consts.vh"
`timescale 1ns/1ps
module gate_motion_controller #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_enhanced,
  input wire i_stop_nc,
  input wire i_open_limit_nc,
  input wire i_closed_limit_nc,
  input wire i_safety_bar_nc,
  input wire i_open_switch,
  input wire i_close_switch,
  input wire i_cord_open,
  input wire i_cord_close,
  input wire i_remote_open_command,
  input wire i_remote_close_command,
  output reg o_motor_open,
  output reg o_motor_close,
  output reg o_warning_light,
  output reg o_remote_gate_open_indication,
  output reg o_remote_gate_closed_indication
);
  wire tick;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`MS_W-1:0] warn_ms_reg;
  reg [`MS_W-1:0] flash_ms_reg;
  reg flash_reg;
  reg cord_run_reg;
  reg cord_run_next;

  wire stop_act = ~i_stop_nc;
  wire at_open = ~i_open_limit_nc;
  wire at_closed = ~i_closed_limit_nc;
  wire bar_act = ~i_safety_bar_nc;

  wire any_open = i_open_switch | i_cord_open | i_remote_open_command;
  wire any_close = i_close_switch | i_cord_close | i_remote_close_command;
  wire cord_any = i_cord_open | i_cord_close;

  gate_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) timebase_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .o_tick(tick)
  );

  wire warn_done = (warn_ms_reg == `WARN_TIME_MS - 1) & tick;

  always @* begin
    state_next = state_reg;
    cord_run_next = cord_run_reg;
    case (state_reg)
      `ST_IDLE: begin
        cord_run_next = 1'b0;
        if (!stop_act) begin
          if (any_open && !any_close && !at_open) begin
            state_next = `ST_WARN_OPEN;
            cord_run_next = i_cord_open;
          end else if (any_close && !any_open && !at_closed && !bar_act) begin
            state_next = `ST_WARN_CLOSE;
            cord_run_next = i_cord_close;
          end
        end
      end
      `ST_WARN_OPEN: begin
        if (stop_act || at_open)
          state_next = `ST_IDLE;
        else if (warn_done)
          state_next = `ST_OPENING;
      end
      `ST_WARN_CLOSE: begin
        if (stop_act || at_closed)
          state_next = `ST_IDLE;
        else if (bar_act && i_enhanced)
          state_next = `ST_WARN_OPEN;
        else if (bar_act)
          state_next = `ST_IDLE;
        else if (warn_done)
          state_next = `ST_CLOSING;
      end
      `ST_OPENING: begin
        if (at_open || (stop_act && !cord_run_reg))
          state_next = `ST_IDLE;
      end
      `ST_CLOSING: begin
        if (at_closed || bar_act || (stop_act && !cord_run_reg))
          state_next = `ST_IDLE;
        if (bar_act && i_enhanced && !at_open) begin
          state_next = `ST_WARN_OPEN;
          cord_run_next = 1'b0;
        end
      end
      default: state_next = `ST_IDLE;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= `ST_IDLE;
      cord_run_reg <= 1'b0;
      warn_ms_reg <= 13'h0000;
      flash_ms_reg <= 13'h0000;
      flash_reg <= 1'b0;
      o_motor_open <= 1'b0;
      o_motor_close <= 1'b0;
      o_warning_light <= 1'b0;
      o_remote_gate_open_indication <= 1'b0;
      o_remote_gate_closed_indication <= 1'b0;
    end else begin
      state_reg <= state_next;
      cord_run_reg <= cord_run_next;
      if (state_next != state_reg)
        warn_ms_reg <= 13'h0000;
      else if (tick)
        warn_ms_reg <= warn_ms_reg + 13'h0001;
      if (state_next == `ST_IDLE) begin
        flash_ms_reg <= 13'h0000;
        flash_reg <= 1'b0;
      end else if (state_reg == `ST_IDLE) begin
        flash_ms_reg <= 13'h0000;
        flash_reg <= 1'b1;
      end else if (tick) begin
        if (flash_ms_reg == `FLASH_HALF_MS - 1) begin
          flash_ms_reg <= 13'h0000;
          flash_reg <= ~flash_reg;
        end else begin
          flash_ms_reg <= flash_ms_reg + 13'h0001;
        end
      end
      o_warning_light <= (state_next != `ST_IDLE) &
        ((state_reg == `ST_IDLE) | flash_reg);
      o_motor_open <= (state_next == `ST_OPENING);
      o_motor_close <= (state_next == `ST_CLOSING);
      o_remote_gate_open_indication <= at_open;
      o_remote_gate_closed_indication <= at_closed;
    end
  end
endmodule // gate_motion_controller

// ### src/gate_timebase.v
`timescale 1ns/1ps
module gate_timebase #(
  parameter TICK_CYCLES = 10000
) (
  input wire i_clk,
  input wire i_reset,
  output reg o_tick
);
  reg [`TICK_W-1:0] count_reg;
  always @(posedge i_clk) begin
    if (i_reset) begin
      count_reg <= 14'h0000;
      o_tick <= 1'b0;
    end else if (count_reg == TICK_CYCLES - 1) begin
      count_reg <= 14'h0000;
      o_tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 14'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule // gate_timebase

// ### tb/gate_monitor.sv
`timescale 1ns/1ps
module gate_monitor #(parameter TICK_CYCLES = 2) (
  input wire i_clk, i_reset, i_safety_bar_nc, i_open_limit_nc,
  input wire i_closed_limit_nc, o_motor_open, o_motor_close,
  input wire o_warning_light, o_remote_gate_open_indication
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  localparam int LIM = 1001 * TICK_CYCLES + 2;
  logic [15:0] stay_reg;
  wire mov = o_motor_open | o_motor_close;
  // Cycles since the light last changed
  always_ff @(posedge i_clk)
    stay_reg <= i_reset | $changed(o_warning_light) ? '0 : stay_reg + 1'b1;
  a_excl_run: assert property (!(o_motor_open & o_motor_close))
    else $error("both motors on");
  a_rev_gap: assert property ($fell(o_motor_close) |-> !o_motor_open[*8])
    else $error("fast reversal");
  a_fwd_gap: assert property ($fell(o_motor_open) |-> !o_motor_close[*8])
    else $error("fast reversal");
  a_flash_run: assert property (mov |-> stay_reg < LIM)
    else $error("light not flashing");
  a_bar_close: assert property (!i_safety_bar_nc |=> !o_motor_close)
    else $error("closing on bar");
  a_open_lim: assert property (!i_open_limit_nc |=> !o_motor_open)
    else $error("past open limit");
  a_shut_lim: assert property (!i_closed_limit_nc |=> !o_motor_close)
    else $error("past closed limit");
  a_open_ind: assert property (!$past(i_reset) |->
    o_remote_gate_open_indication == !$past(i_open_limit_nc))
    else $error("open indication");
  cover property ($rose(o_motor_open));
  cover property ($rose(o_motor_close));
  cover property ($fell(o_motor_close) && !i_safety_bar_nc);
endmodule // gate_monitor
bind gate_motion_controller gate_monitor #(.TICK_CYCLES(TICK_CYCLES))
  mon_u (.*);

// ### tb/gate_plant.sv
`timescale 1ns/1ps
module gate_plant (
  input wire i_clk, o_motor_open, o_motor_close,
  output wire i_open_limit_nc, i_closed_limit_nc
);
  int pos_reg = 0;
  always @(posedge i_clk)
    pos_reg <= pos_reg + int'(o_motor_open && pos_reg < 40)
      - int'(o_motor_close && pos_reg > 0);
  // contacts open at each end stop
  assign i_open_limit_nc = pos_reg != 40;
  assign i_closed_limit_nc = pos_reg != 0;
endmodule // gate_plant

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_clk = 0, i_reset = 1, i_enhanced = 0;
  logic i_stop_nc = 1, i_safety_bar_nc = 1;
  logic [5:0] s = 6'h00;
  wire i_open_switch = s[0], i_close_switch = s[1], i_cord_open = s[4];
  wire i_remote_open_command = s[2], i_remote_close_command = s[3];
  wire i_cord_close = s[5], i_open_limit_nc, i_closed_limit_nc;
  wire o_motor_open, o_motor_close, o_warning_light;
  wire o_remote_gate_open_indication, o_remote_gate_closed_indication;
  wire [1:0] ind = {o_remote_gate_open_indication,
    o_remote_gate_closed_indication};
  wire [1:0] m = {o_motor_open, o_motor_close};
  int err_count = 0, checks_done = 0, n;
  always #50 i_clk = ~i_clk;
  gate_plant pl_u (.*);
  gate_motion_controller #(.TICK_CYCLES(2)) dut_u (.*);
  task finish_test;
    $display("%0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [1:0] got, exp);
    checks_done++;
    err_count += int'(got !== exp);
    if (got !== exp) $display("mismatch %0t %h %h", $time, got, exp);
  endtask
  // Raise start input b for k cycles; b = 6 just waits
  task go(input int b, input int k);
    s = 6'h01 << b;
    repeat (k) @(posedge i_clk);
    #1 s = 6'h00;
  endtask
  task wm(input logic [1:0] w);
    for (n = 0; m !== w && n < 30000; n++) go(6, 1);
    err_count += int'(n == 30000);
    if (n == 30000) finish_test;
  endtask
  task t_open;
    go(0, 1);
    go(6, 1);
    chk({1'b0, o_warning_light}, 2'h1);
    wm(2'h2);
    chk({1'b0, n > 9995 && n < 10006}, 2'h1);
    wm(2'h0);
    go(6, 2);
    chk(ind, 2'h2);
    $display("open test done");
  endtask
  task t_close;
    go(1, 1);
    wm(2'h1);
    go(2, 3);
    chk(m, 2'h1);
    i_stop_nc = 0;
    go(6, 2);
    chk(m, 2'h0);
    chk(ind, 2'h0);
    i_stop_nc = 1;
    $display("close test done");
  endtask
  task t_cord;
    i_enhanced = 1;
    go(5, 1);
    wm(2'h1);
    i_stop_nc = 0;
    go(6, 3);
    chk(m, 2'h1);
    i_stop_nc = 1;
    i_safety_bar_nc = 0;
    go(6, 2);
    chk(m, 2'h0);
    wm(2'h2);
    chk({1'b0, n > 9995 && n < 10006}, 2'h1);
    i_safety_bar_nc = 1;
    i_enhanced = 0;
    wm(2'h0);
    go(3, 1);
    wm(2'h1);
    wm(2'h0);
    go(6, 2);
    chk(ind, 2'h1);
    $display("cord test done");
  endtask
  initial begin
    go(6, 10);
    i_reset = 0;
    go(6, 1);
    t_open;
    t_close;
    t_cord;
    finish_test;
  end
endmodule // tb
